// ==== src/afx_pkg.sv ====
package afx_pkg;
    // operation codes presented on the command port
    typedef enum logic [5:0] {
        AFX_ADD, AFX_ADC, AFX_WORD_IMMEDIATE_SUM, AFX_SUB, AFX_DIFFERENCE_LITERAL,
        AFX_DIFFERENCE_WITH_BORROW, AFX_LITERAL_DIFFERENCE_BORROW,
        AFX_WORD_IMMEDIATE_DIFFERENCE, AFX_AND, AFX_CONJUNCTION_LITERAL, AFX_OR,
        AFX_DISJUNCTION_LITERAL, AFX_EXCLUSIVE_DISJUNCTION, AFX_COM, AFX_TWOS_INVERSE,
        AFX_BIT_SET_MASK, AFX_BIT_CLEAR_MASK, AFX_INC, AFX_STEP_DOWN,
        AFX_ZERO_SIGN_CHECK, AFX_ZERO_FILL, AFX_ALL_ONES_FILL, AFX_RELATIVE_GOTO,
        AFX_POINTER_GOTO, AFX_RELATIVE_SUBROUTINE_ENTRY, AFX_POINTER_SUBROUTINE_ENTRY,
        AFX_SUBROUTINE_EXIT, AFX_INTERRUPT_EXIT, AFX_EQUAL_SKIP_CHECK, AFX_CP,
        AFX_COMPARE_WITH_BORROW, AFX_COMPARE_LITERAL, AFX_NOP
    } afx_op_t;

    // status register bit positions
    localparam int AFX_FLAG_C = 0;
    localparam int AFX_FLAG_Z = 1;
    localparam int AFX_FLAG_N = 2;
    localparam int AFX_FLAG_V = 3;
    localparam int AFX_FLAG_S = 4;
    localparam int AFX_FLAG_H = 5;
    localparam int AFX_FLAG_I = 7;

    // constants and cycle counts
    localparam logic [7:0] AFX_ALL_ONES = 8'hFF;
    localparam logic [7:0] AFX_ZERO_BYTE = 8'h00;
    localparam logic [7:0] AFX_SREG_RESET = 8'h00;
    localparam logic [15:0] AFX_PC_RESET = 16'h0000;
    localparam logic [2:0] AFX_CYC_ONE = 3'h1;
    localparam logic [2:0] AFX_CYC_WORD = 3'h2;
    localparam logic [2:0] AFX_CYC_JUMP = 3'h2;
    localparam logic [2:0] AFX_CYC_CALL = 3'h3;
    localparam logic [2:0] AFX_CYC_RET = 3'h4;
    localparam logic [15:0] AFX_SKIP_SHORT = 16'h0002;
    localparam logic [15:0] AFX_SKIP_LONG = 16'h0003;

    // one instruction as presented to the block
    typedef struct packed {
        afx_op_t op;
        logic [7:0] dst;
        logic [7:0] src;
        logic [7:0] imm;
        logic [15:0] pair;
        logic [11:0] offset;
        logic [15:0] pointer;
        logic [15:0] stack_pc;
        logic next_is_long;
    } afx_cmd_t;

    // outcome of one instruction
    typedef struct packed {
        logic [7:0] result;
        logic result_we;
        logic [15:0] pair_result;
        logic pair_we;
        logic [15:0] pc;
        logic push;
        logic pop;
    } afx_res_t;
endpackage

// ==== src/afx_exec.sv ====
`timescale 1ns/1ns
module afx_exec (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // command side
    input wire logic cmd_valid,
    input wire afx_pkg::afx_cmd_t cmd,
    output logic cmd_ready,
    // results
    output logic res_valid,
    output afx_pkg::afx_res_t res,
    output logic [7:0] sreg,
    output logic [15:0] pc
);
    // byte add with carry in; returns {h, c, sum}
    function automatic logic [9:0] afx_add8(input logic [7:0] a, input logic [7:0] b,
                                            input logic ci);
        logic [8:0] s;
        logic [4:0] lo;
        s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        return {lo[4], s[8], s[7:0]};
    endfunction

    // byte subtract with borrow in; returns {h, c, diff}
    function automatic logic [9:0] afx_sub8(input logic [7:0] a, input logic [7:0] b,
                                            input logic bi);
        logic [8:0] d;
        logic [4:0] lo;
        d = {1'b0, a} - {1'b0, b} - {8'h00, bi};
        lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bi};
        return {lo[4], d[8], d[7:0]};
    endfunction

    logic [7:0] sreg_r, sreg_nxt;
    logic [15:0] pc_r, pc_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic busy_r;
    afx_pkg::afx_res_t res_r, res_nxt;
    logic res_valid_r;

    wire logic c_in = sreg_r[afx_pkg::AFX_FLAG_C];
    wire logic [7:0] d = cmd.dst;
    wire logic [7:0] r = cmd.src;
    wire logic [7:0] k = cmd.imm;
    wire logic [15:0] sext_off = {{4{cmd.offset[11]}}, cmd.offset};
    wire logic [15:0] rel_target = pc_r + sext_off + 16'h0001;
    wire logic [15:0] seq_pc = pc_r + 16'h0001;
    wire logic [16:0] word_sum = {1'b0, cmd.pair} + {11'h000, k[5:0]};
    wire logic [16:0] word_dif = {1'b0, cmd.pair} - {11'h000, k[5:0]};
    wire logic take = cmd_valid && cmd_ready;
    // subtract operands as the overflow sees them; twos inverse is zero minus d
    wire logic neg_op = (cmd.op == afx_pkg::AFX_TWOS_INVERSE);
    wire logic lit_op = (cmd.op == afx_pkg::AFX_DIFFERENCE_LITERAL) ||
                        (cmd.op == afx_pkg::AFX_LITERAL_DIFFERENCE_BORROW) ||
                        (cmd.op == afx_pkg::AFX_COMPARE_LITERAL);
    wire logic [7:0] sub_a = neg_op ? afx_pkg::AFX_ZERO_BYTE : d;
    wire logic [7:0] sub_b = neg_op ? d : (lit_op ? k : r);

    assign cmd_ready = !busy_r;

    // decode: result, flags, pc and cycle count for the accepted instruction
    always_comb begin
        logic [9:0] ar;
        logic [7:0] lr;
        logic arith, logic_op, sub_op, word_op, keepz;
        logic [15:0] wr;
        ar = 10'h000;
        lr = 8'h00;
        arith = 1'b0;
        logic_op = 1'b0;
        sub_op = 1'b0;
        word_op = 1'b0;
        keepz = 1'b0;
        wr = 16'h0000;
        sreg_nxt = sreg_r;
        res_nxt = '0;
        res_nxt.pc = seq_pc;
        cnt_nxt = afx_pkg::AFX_CYC_ONE;
        case (cmd.op)
            afx_pkg::AFX_ADD: begin
                ar = afx_add8(d, r, 1'b0);
                arith = 1'b1;
            end
            afx_pkg::AFX_ADC: begin
                ar = afx_add8(d, r, c_in);
                arith = 1'b1;
            end
            afx_pkg::AFX_SUB: begin
                ar = afx_sub8(d, r, 1'b0);
                arith = 1'b1;
                sub_op = 1'b1;
            end
            afx_pkg::AFX_DIFFERENCE_LITERAL: begin
                ar = afx_sub8(d, k, 1'b0);
                arith = 1'b1;
                sub_op = 1'b1;
            end
            afx_pkg::AFX_DIFFERENCE_WITH_BORROW: begin
                ar = afx_sub8(d, r, c_in);
                arith = 1'b1;
                sub_op = 1'b1;
                keepz = 1'b1;
            end
            afx_pkg::AFX_LITERAL_DIFFERENCE_BORROW: begin
                ar = afx_sub8(d, k, c_in);
                arith = 1'b1;
                sub_op = 1'b1;
                keepz = 1'b1;
            end
            afx_pkg::AFX_TWOS_INVERSE: begin
                ar = afx_sub8(afx_pkg::AFX_ZERO_BYTE, d, 1'b0);
                arith = 1'b1;
                sub_op = 1'b1;
            end
            afx_pkg::AFX_CP: begin
                ar = afx_sub8(d, r, 1'b0);
                arith = 1'b1;
                sub_op = 1'b1;
            end
            afx_pkg::AFX_COMPARE_WITH_BORROW: begin
                ar = afx_sub8(d, r, c_in);
                arith = 1'b1;
                sub_op = 1'b1;
                keepz = 1'b1;
            end
            afx_pkg::AFX_COMPARE_LITERAL: begin
                ar = afx_sub8(d, k, 1'b0);
                arith = 1'b1;
                sub_op = 1'b1;
            end
            afx_pkg::AFX_AND: begin
                lr = d & r;
                logic_op = 1'b1;
            end
            afx_pkg::AFX_CONJUNCTION_LITERAL: begin
                lr = d & k;
                logic_op = 1'b1;
            end
            afx_pkg::AFX_OR: begin
                lr = d | r;
                logic_op = 1'b1;
            end
            afx_pkg::AFX_DISJUNCTION_LITERAL, afx_pkg::AFX_BIT_SET_MASK: begin
                lr = d | k;
                logic_op = 1'b1;
            end
            afx_pkg::AFX_EXCLUSIVE_DISJUNCTION, afx_pkg::AFX_ZERO_FILL: begin
                lr = (cmd.op == afx_pkg::AFX_ZERO_FILL) ? (d ^ d) : (d ^ r);
                logic_op = 1'b1;
            end
            afx_pkg::AFX_BIT_CLEAR_MASK: begin
                lr = d & (afx_pkg::AFX_ALL_ONES - k);
                logic_op = 1'b1;
            end
            afx_pkg::AFX_ZERO_SIGN_CHECK: begin
                lr = d & d;
                logic_op = 1'b1;
            end
            afx_pkg::AFX_INC, afx_pkg::AFX_STEP_DOWN: begin
                // overflow only at the signed wrap point
                lr = (cmd.op == afx_pkg::AFX_INC) ? d + 8'h01 : d - 8'h01;
                res_nxt.result = lr;
                res_nxt.result_we = 1'b1;
                sreg_nxt[afx_pkg::AFX_FLAG_Z] = (lr == 8'h00);
                sreg_nxt[afx_pkg::AFX_FLAG_N] = lr[7];
                sreg_nxt[afx_pkg::AFX_FLAG_V] = (cmd.op == afx_pkg::AFX_INC) ?
                    (d == 8'h7F) : (d == 8'h80);
            end
            afx_pkg::AFX_COM: begin
                lr = afx_pkg::AFX_ALL_ONES - d;
                res_nxt.result = lr;
                res_nxt.result_we = 1'b1;
                sreg_nxt[afx_pkg::AFX_FLAG_Z] = (lr == 8'h00);
                sreg_nxt[afx_pkg::AFX_FLAG_C] = 1'b1;
                sreg_nxt[afx_pkg::AFX_FLAG_N] = lr[7];
                sreg_nxt[afx_pkg::AFX_FLAG_V] = 1'b0;
            end
            afx_pkg::AFX_ALL_ONES_FILL: begin
                res_nxt.result = afx_pkg::AFX_ALL_ONES;
                res_nxt.result_we = 1'b1;
            end
            afx_pkg::AFX_WORD_IMMEDIATE_SUM: begin
                wr = word_sum[15:0];
                word_op = 1'b1;
                sreg_nxt[afx_pkg::AFX_FLAG_C] = word_sum[16];
                sreg_nxt[afx_pkg::AFX_FLAG_V] = !cmd.pair[15] && wr[15];
            end
            afx_pkg::AFX_WORD_IMMEDIATE_DIFFERENCE: begin
                wr = word_dif[15:0];
                word_op = 1'b1;
                sreg_nxt[afx_pkg::AFX_FLAG_C] = word_dif[16];
                sreg_nxt[afx_pkg::AFX_FLAG_V] = cmd.pair[15] && !wr[15];
            end
            afx_pkg::AFX_RELATIVE_GOTO: begin
                res_nxt.pc = rel_target;
                cnt_nxt = afx_pkg::AFX_CYC_JUMP;
            end
            afx_pkg::AFX_POINTER_GOTO: begin
                res_nxt.pc = cmd.pointer;
                cnt_nxt = afx_pkg::AFX_CYC_JUMP;
            end
            afx_pkg::AFX_RELATIVE_SUBROUTINE_ENTRY: begin
                res_nxt.pc = rel_target;
                res_nxt.push = 1'b1;
                cnt_nxt = afx_pkg::AFX_CYC_CALL;
            end
            afx_pkg::AFX_POINTER_SUBROUTINE_ENTRY: begin
                res_nxt.pc = cmd.pointer;
                res_nxt.push = 1'b1;
                cnt_nxt = afx_pkg::AFX_CYC_CALL;
            end
            afx_pkg::AFX_SUBROUTINE_EXIT, afx_pkg::AFX_INTERRUPT_EXIT: begin
                res_nxt.pc = cmd.stack_pc;
                res_nxt.pop = 1'b1;
                cnt_nxt = afx_pkg::AFX_CYC_RET;
                if (cmd.op == afx_pkg::AFX_INTERRUPT_EXIT) begin
                    sreg_nxt[afx_pkg::AFX_FLAG_I] = 1'b1;
                end
            end
            afx_pkg::AFX_EQUAL_SKIP_CHECK: begin
                // cycles are 1 + skipped words
                if (d == r) begin
                    res_nxt.pc = pc_r + (cmd.next_is_long ? afx_pkg::AFX_SKIP_LONG :
                                                            afx_pkg::AFX_SKIP_SHORT);
                    cnt_nxt = cmd.next_is_long ? afx_pkg::AFX_CYC_CALL :
                                                 afx_pkg::AFX_CYC_WORD;
                end
            end
            default: begin
                res_nxt.pc = seq_pc;
            end
        endcase
        // shared flag logic for byte arithmetic
        if (arith) begin
            res_nxt.result = ar[7:0];
            res_nxt.result_we = (cmd.op != afx_pkg::AFX_CP) &&
                                (cmd.op != afx_pkg::AFX_COMPARE_WITH_BORROW) &&
                                (cmd.op != afx_pkg::AFX_COMPARE_LITERAL);
            sreg_nxt[afx_pkg::AFX_FLAG_C] = ar[8];
            sreg_nxt[afx_pkg::AFX_FLAG_H] = ar[9];
            sreg_nxt[afx_pkg::AFX_FLAG_N] = ar[7];
            // borrow forms keep zero sticky so multi-byte compares chain
            sreg_nxt[afx_pkg::AFX_FLAG_Z] = (ar[7:0] == 8'h00) &&
                (!keepz || sreg_r[afx_pkg::AFX_FLAG_Z]);
            // signed overflow: result leaves sub_a's sign while operand signs differ for subtracts, d's sign while they match for adds
            sreg_nxt[afx_pkg::AFX_FLAG_V] = sub_op ?
                ((sub_a[7] != sub_b[7]) && (ar[7] != sub_a[7])) :
                ((d[7] == r[7]) && (ar[7] != d[7]));
        end
        if (logic_op) begin
            res_nxt.result = lr;
            res_nxt.result_we = 1'b1;
            sreg_nxt[afx_pkg::AFX_FLAG_Z] = (lr == 8'h00);
            sreg_nxt[afx_pkg::AFX_FLAG_N] = lr[7];
            sreg_nxt[afx_pkg::AFX_FLAG_V] = 1'b0;
        end
        if (word_op) begin
            res_nxt.pair_result = wr;
            res_nxt.pair_we = 1'b1;
            sreg_nxt[afx_pkg::AFX_FLAG_Z] = (wr == 16'h0000);
            sreg_nxt[afx_pkg::AFX_FLAG_N] = wr[15];
            sreg_nxt[afx_pkg::AFX_FLAG_S] = wr[15] ^ sreg_nxt[afx_pkg::AFX_FLAG_V];
            cnt_nxt = afx_pkg::AFX_CYC_WORD;
        end
        pc_nxt = res_nxt.pc;
    end

    // busy counter holds off new work for multi-cycle instructions
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy_r <= 1'b0;
            cnt_r <= 3'h0;
        end else if (take) begin
            busy_r <= (cnt_nxt != afx_pkg::AFX_CYC_ONE);
            cnt_r <= cnt_nxt - 3'h1;
        end else if (busy_r) begin
            busy_r <= (cnt_r != 3'h1);
            cnt_r <= cnt_r - 3'h1;
        end
    end

    // architectural state and result capture at issue
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sreg_r <= afx_pkg::AFX_SREG_RESET;
            pc_r <= afx_pkg::AFX_PC_RESET;
            res_r <= '0;
            res_valid_r <= 1'b0;
        end else begin
            res_valid_r <= take && (cnt_nxt == afx_pkg::AFX_CYC_ONE) ||
                           busy_r && (cnt_r == 3'h1);
            if (take) begin
                sreg_r <= sreg_nxt;
                pc_r <= pc_nxt;
                res_r <= res_nxt;
            end
        end
    end

    assign res_valid = res_valid_r;
    assign res = res_r;
    assign sreg = sreg_r;
    assign pc = pc_r;
endmodule

// ==== sim/afx_exec_checker.sv ====
`timescale 1ns/1ns
module afx_exec_checker (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // command side
    input wire logic cmd_valid,
    input wire afx_pkg::afx_cmd_t cmd,
    input wire logic cmd_ready,
    // results
    input wire logic res_valid,
    input wire afx_pkg::afx_res_t res,
    input wire logic [7:0] sreg,
    input wire logic [15:0] pc
);
    // op classes by enum position, cheaper than long name lists
    wire logic [5:0] k = cmd.op;
    wire logic acc = cmd_valid && cmd_ready;
    wire logic is_word = (k == 6'h02) || (k == 6'h07);
    wire logic is_jmp = (k == 6'h16) || (k == 6'h17);
    wire logic is_call = (k == 6'h18) || (k == 6'h19);
    wire logic is_ret = (k == 6'h1A) || (k == 6'h1B);
    wire logic is_skip = (k == 6'h1C);
    wire logic is_one = !(is_word || is_jmp || is_call || is_ret || is_skip);

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // cycle counts per instruction class
    alu_single_a: assert property (
        acc && is_one |=> res_valid && cmd_ready)
        else $error("single cycle op late");
    word_timing_a: assert property (
        acc && is_word |=> !res_valid ##1 res_valid)
        else $error("word op timing wrong");
    jump_timing_a: assert property (
        acc && is_jmp |=> !res_valid ##1 res_valid)
        else $error("jump timing wrong");
    call_timing_a: assert property (
        acc && is_call |=> !cmd_ready [*2] ##1 res_valid)
        else $error("call timing wrong");
    ret_timing_a: assert property (
        acc && is_ret |=> !res_valid [*3] ##1 res_valid)
        else $error("return timing wrong");
    // program counter and flag effects
    skip_pc_a: assert property (
        acc && is_skip && cmd.dst == cmd.src |=>
        pc == $past(pc) + ($past(cmd.next_is_long) ? 16'h0003 : 16'h0002))
        else $error("skip distance wrong");
    skip_flags_a: assert property (
        acc && is_skip |=> sreg == $past(sreg))
        else $error("skip changed flags");
    fill_ones_a: assert property (
        acc && k == 6'h15 |=> res.result == 8'hFF && $stable(sreg))
        else $error("all ones fill wrong");
    interrupt_exit_ie_a: assert property (
        acc && k == 6'h1B |=> sreg[7] && pc == $past(cmd.stack_pc))
        else $error("interrupt exit wrong");
    busy_hold_a: assert property (
        !cmd_ready |=> $stable(pc))
        else $error("pc moved while busy");

    skip_long_c: cover property (acc && is_skip && cmd.dst == cmd.src && cmd.next_is_long);
    word_c: cover property (acc && is_word);
    interrupt_exit_c: cover property (acc && k == 6'h1B);
endmodule

bind afx_exec afx_exec_checker u_chk (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .res_valid(res_valid), .res(res), .sreg(sreg), .pc(pc));

// ==== sim/afx_exec_tb.sv ====
`timescale 1ns/1ns
module afx_exec_tb;
    // op sets by enum position, bit n is op n
    localparam logic [31:0] USE_SRC = 32'h7000_152B;
    localparam logic [31:0] ADDS = 32'h0002_0003;
    localparam logic [31:0] SUBS = 32'hE004_4078;
    localparam logic [31:0] CIN = 32'h4000_0062;
    localparam logic [31:0] ZKEEP = 32'h4000_0060;
    localparam logic [31:0] ANDS = 32'h0009_0300;
    localparam logic [31:0] ORS = 32'h0000_8C00;
    localparam logic [31:0] XORS = 32'h0010_1000;
    localparam logic [31:0] NOWR = 32'hFFC0_0084;
    typedef struct packed {
        logic [7:0] r;
        logic rwe;
        logic [15:0] pr;
        logic pwe;
        logic [15:0] pc;
        logic psh;
        logic pop;
        logic [7:0] sr;
        logic [7:0] msk;
        logic [2:0] n;
        logic [31:0] t;
    } afx_note_t;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid = 1'b0;
    afx_pkg::afx_cmd_t cmd = '0;
    logic cmd_ready;
    logic res_valid;
    afx_pkg::afx_res_t res;
    logic [7:0] sreg;
    logic [15:0] pc;
    int num_errors = 0;
    int checked = 0;
    logic [31:0] cnt = 32'h0000_0000;
    integer seed = 32'he413;
    logic [7:0] esr;
    logic [15:0] epc;
    afx_note_t notes[$];
    afx_note_t m;
    afx_pkg::afx_cmd_t c;
    logic [95:0] rv;
    int i;
    int p;

    always #5 clk = ~clk;

    afx_exec DUT (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .res_valid(res_valid), .res(res), .sreg(sreg), .pc(pc));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // reference model, then offer until taken and queue the note
    task automatic issue(input afx_pkg::afx_cmd_t c);
        afx_note_t n;
        logic [7:0] d;
        logic [7:0] s;
        logic [7:0] r;
        logic [8:0] w;
        logic [4:0] h;
        logic [16:0] q;
        logic [5:0] f;
        logic [5:0] um;
        logic b;
        logic v;
        logic ar;
        int k;
        k = int'(c.op);
        n = '0;
        n.n = 3'h1;
        n.msk = 8'hAF;
        n.pc = epc + 16'h0001;
        n.rwe = !NOWR[k];
        d = (k == 14) ? 8'h00 : c.dst;
        s = (k == 17 || k == 18) ? 8'h01 : (k == 16) ? ~c.imm :
            (k == 14 || k == 19 || k == 20) ? c.dst : USE_SRC[k] ? c.src : c.imm;
        b = CIN[k] & esr[0];
        ar = ADDS[k] | SUBS[k];
        w = ADDS[k] ? {1'b0, d} + s + b : {1'b0, d} - s - b;
        h = ADDS[k] ? d[3:0] + s[3:0] + b : d[3:0] - s[3:0] - b;
        r = ANDS[k] ? d & s : ORS[k] ? d | s : XORS[k] ? d ^ s :
            (k == 13) ? ~d : (k == 21) ? 8'hFF : w[7:0];
        v = ar && ((d[7] ^ s[7]) != ADDS[k]) && (r[7] != d[7]);
        f = {h[4], 1'b0, v, r[7], (r == 8'h00) && (!ZKEEP[k] || esr[1]), !ar || w[8]};
        um = (k == 13) ? 6'h0F : (k == 17 || k == 18 || ANDS[k] || ORS[k] || XORS[k]) ? 6'h0E :
            ar ? 6'h2F : 6'h00;
        if (k == 2 || k == 7) begin
            q = (k == 2) ? {1'b0, c.pair} + c.imm[5:0] : {1'b0, c.pair} - c.imm[5:0];
            v = (k == 2) ? !c.pair[15] && q[15] : c.pair[15] && !q[15];
            f = {1'b0, q[15] ^ v, v, q[15], q[15:0] == 16'h0000, q[16]};
            um = 6'h1F;
            n.msk = 8'hBF;
            n.n = 3'h2;
            n.pr = q[15:0];
            n.pwe = 1'b1;
        end
        // flow ops: returns take stack_pc; of the rest, odd positions take the pointer, even the offset
        if (k >= 22 && k <= 27) begin
            n.n = (k < 24) ? 3'h2 : (k < 26) ? 3'h3 : 3'h4;
            n.pc = (k >= 26) ? c.stack_pc : k[0] ? c.pointer :
                epc + {{4{c.offset[11]}}, c.offset} + 16'h0001;
            n.psh = (k == 24 || k == 25);
            n.pop = (k >= 26);
            esr[7] = esr[7] | (k == 27);
        end
        if (k == 28 && c.dst == c.src) begin
            n.n = c.next_is_long ? 3'h3 : 3'h2;
            n.pc = epc + {13'h0000, n.n};
        end
        esr[5:0] = (esr[5:0] & ~um) | (f & um);
        n.r = r;
        n.sr = esr;
        epc = n.pc;
        cmd = c;
        cmd_valid = 1'b1;
        do begin
            @(posedge clk);
        end while (cmd_ready !== 1'b1);
        n.t = cnt;
        notes.push_back(n);
        #1;
    endtask

    // cycle count and hang guard
    always @(posedge clk) begin
        cnt <= cnt + 32'h0000_0001;
        if (cnt == 32'h0000_2000) begin
            num_errors++;
            wrap_up;
        end
    end

    // settled outputs are compared mid-cycle against the oldest note
    always @(negedge clk) begin
        if (res_valid === 1'b1) begin
            if (notes.size() == 0) begin
                check(32'h0000_0001, 32'h0000_0000);
            end else begin
                m = notes.pop_front();
                check(cnt - m.t, {29'h0000_0000, m.n});
                check(pc, m.pc);
                check(res.pc, m.pc);
                check(sreg & m.msk, m.sr & m.msk);
                check({res.result_we, res.pair_we, res.push, res.pop},
                    {m.rwe, m.pwe, m.psh, m.pop});
                if (m.rwe) begin
                    check(res.result, m.r);
                end
                if (m.pwe) begin
                    check(res.pair_result, m.pr);
                end
            end
        end
    end

    // two passes, the second after a short reset in mid-run
    initial begin
        for (p = 0; p < 2; p++) begin
            cmd_valid = 1'b0;
            sys_rst = 1'b1;
            repeat ((p == 0) ? 10 : 2) @(posedge clk);
            #1;
            sys_rst = 1'b0;
            esr = 8'h00;
            epc = 16'h0000;
            check({cmd_ready, sreg, pc}, 25'h100_0000);
            for (i = 0; i < 320; i++) begin
                rv = {$random(seed), $random(seed), $random(seed)};
                c = rv[90:0];
                c.op = afx_pkg::afx_op_t'(i % 32);
                // equal operands and pair extremes hit zero and carry edges
                if (rv[95]) begin
                    c.src = c.dst;
                    c.imm = c.dst;
                    c.pair = {16{rv[94]}};
                end
                issue(c);
                if (rv[93]) begin
                    cmd_valid = 1'b0;
                    @(posedge clk);
                    #1;
                end
            end
            cmd_valid = 1'b0;
            repeat (6) @(posedge clk);
            #1;
            check(notes.size(), 32'h0000_0000);
        end
        wrap_up;
    end
endmodule
